//--- verilog/spi_port_pkg.sv
// constants and types shared by the serial peripheral port
// What this block does
// - outputs drive pins only with direction bit set
// - role inputs are inputs whatever the direction bit
// - miso input as master, output as slave
// - mosi output as master, input as slave
// - both data lines shift msb first
// - unselected slave floats its miso output
// - one byte per exactly eight serial clocks
// - only master drives sck; slave samples it
// - polarity and phase pick four timings
// - master presents data half period before capture
// - rate bits matter only in master mode
// - master bit rate never above 1.5 MHz
// - slave accepts bit rates up to 3 MHz
// - master or slave; clock on own line
// - full duplex: one bit out, one in
// - master sck is clock over 2,4,16,32
// - idle master sck equals polarity bit
package spi_port_pkg;
  localparam int CLK_MHZ            = 200;
  localparam int MASTER_MAX_KHZ     = 1500;
  localparam int SLAVE_MAX_KHZ      = 3000;
  // processor clock seen by the port is the core clock pre-divided to keep the master rate legal
  localparam int EPRE_DIV           = (CLK_MHZ * 1000 + 2 * MASTER_MAX_KHZ - 1) / (2 * MASTER_MAX_KHZ);
  localparam int BITS_PER_BYTE      = 8;
  localparam int DIV_SEL0           = 2;
  localparam int DIV_SEL1           = 4;
  localparam int DIV_SEL2           = 16;
  localparam int DIV_SEL3           = 32;
  localparam int FIFO_DEPTH         = 16;
  localparam int DATA_W             = 8;
  localparam logic [7:0] SHIFT_RST  = 8'h00;
  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_SHIFT = 3'b010,
    M_DONE  = 3'b100
  } mstate_t;
endpackage : spi_port_pkg

//--- verilog/spi_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module spi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output      logic             in_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // honest full and empty from the occupancy count
  always_comb
  begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push)
        mem[wr_ptr] <= in_data;
    end
  end

  // head word shown directly; storage array acts as the output register
  assign out_data = mem[rd_ptr];
endmodule : spi_fifo

//--- verilog/spi_rate_gen.sv
// master bit-rate tick generator for the four rate codes
`timescale 1ns/100ps
module spi_rate_gen #(
  parameter int PRE = 67
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output      logic       half_tick
);
  logic [7:0] pre_cnt, next_pre_cnt;
  logic [4:0] div_cnt, next_div_cnt;
  logic [4:0] half_len;
  logic       etick;

  // half period in processor clocks per rate code
  always_comb
  begin
    unique case (rate)
      2'b00: half_len = 5'(spi_port_pkg::DIV_SEL0 / 2);
      2'b01: half_len = 5'(spi_port_pkg::DIV_SEL1 / 2);
      2'b10: half_len = 5'(spi_port_pkg::DIV_SEL2 / 2);
      default: half_len = 5'(spi_port_pkg::DIV_SEL3 / 2);
    endcase
    etick        = (pre_cnt == 8'(PRE - 1));
    next_pre_cnt = (!run || etick) ? 8'h00 : pre_cnt + 8'h01;
    next_div_cnt = div_cnt;
    half_tick    = 1'b0;
    if (!run)
      next_div_cnt = 5'h00;
    else if (etick)
    begin
      if (div_cnt == half_len - 5'h01)
      begin
        next_div_cnt = 5'h00;
        half_tick    = 1'b1;
      end
      else
        next_div_cnt = div_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_cnt <= 8'h00;
      div_cnt <= 5'h00;
    end
    else if (ce)
    begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
    end
  end
endmodule : spi_rate_gen

//--- verilog/spi_master_slave_port.sv
// serial peripheral port, master or slave, with transmit fifo
`timescale 1ns/100ps
module spi_master_slave_port #(
  parameter int DEPTH = spi_port_pkg::FIFO_DEPTH,
  parameter int PRE   = spi_port_pkg::EPRE_DIV
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire logic       ENABLE,
  input  wire logic       MASTER_MODE,
  input  wire logic       CLOCK_POLARITY_BIT,
  input  wire logic       CLOCK_PHASE_BIT,
  input  wire logic       RATE_SELECT_LOW,
  input  wire logic       RATE_SELECT_HIGH,
  input  wire logic       DIR_MISO,
  input  wire logic       DIR_MOSI,
  input  wire logic       DIR_SCK,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output      logic       TX_READY,
  output      logic [7:0] RX_DATA,
  output      logic       RX_VALID,
  output      logic       BUSY,
  input  wire logic       MISO_IN,
  output      logic       MISO_OUT,
  output      logic       MISO_OE_N,
  input  wire logic       MOSI_IN,
  output      logic       MOSI_OUT,
  output      logic       MOSI_OE_N,
  input  wire logic       SCK_IN,
  output      logic       SCK_OUT,
  output      logic       SCK_OE_N,
  input  wire logic       SS_N_IN
);
  logic [7:0] fifo_data;
  logic       fifo_valid, fifo_pop;
  logic       half_tick;
  logic       master, slave_sel;

  // fifo between the user and the shift register; stalls user when full
  spi_fifo #(.WIDTH(spi_port_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .ce        (CE),
    .in_data   (TX_DATA),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  spi_port_pkg::mstate_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] edges, next_edges;
  logic       sck_lvl, next_sck_lvl;
  logic       in_bit, next_in_bit;
  logic [7:0] rx, next_rx;
  logic       rxv, next_rxv;
  logic       sck_d, next_sck_d;
  logic       ss_d, next_ss_d;
  logic       sl_bits_z;
  logic [3:0] sl_cnt, next_sl_cnt;
  logic       sl_load, next_sl_load;

  // role selects: the generator only runs as master, so rate bits only matter then
  assign master    = ENABLE && MASTER_MODE;
  assign slave_sel = ENABLE && !MASTER_MODE && !SS_N_IN;

  // clock over 2,4,16,32 of the pre-divided processor clock
  spi_rate_gen #(.PRE(PRE)) u_rate (
    .clk       (CORE_CLK),
    .rst       (RST),
    .ce        (CE),
    .run       (master && state == spi_port_pkg::M_SHIFT),
    .rate      ({RATE_SELECT_HIGH, RATE_SELECT_LOW}),
    .half_tick (half_tick)
  );

  logic mode_a;
  logic sck_lead, sck_trail, s_sample, s_shift;
  logic sck_eff;
  assign mode_a    = ~CLOCK_PHASE_BIT;
  // slave edge detect on the synchronous pin; 200 MHz sampling covers 3 MHz easily
  assign sck_eff   = SCK_IN ^ CLOCK_POLARITY_BIT;
  assign sck_lead  = sck_eff && !sck_d;
  assign sck_trail = !sck_eff && sck_d;
  assign s_sample  = mode_a ? sck_lead : sck_trail;
  assign s_shift   = mode_a ? sck_trail : sck_lead;
  assign sl_bits_z = (sl_cnt == 4'h0);
  assign fifo_pop  = fifo_valid && ((master && state == spi_port_pkg::M_IDLE) ||
                     (!master && slave_sel && sl_load));

  // shift engine for both roles: one bit out and one bit in per clock
  always_comb
  begin
    next_state   = state;
    next_shreg   = shreg;
    next_edges   = edges;
    next_sck_lvl = sck_lvl;
    next_in_bit  = in_bit;
    next_rx      = rx;
    next_rxv     = 1'b0;
    next_sck_d   = sck_eff;
    next_ss_d    = SS_N_IN;
    next_sl_cnt  = sl_cnt;
    next_sl_load = sl_load;
    if (master)
    begin
      unique case (state)
        spi_port_pkg::M_IDLE:
        begin
          next_sck_lvl = 1'b0;
          if (fifo_valid)
          begin
            next_shreg = fifo_data;
            next_edges = 4'h0;
            next_state = spi_port_pkg::M_SHIFT;
          end
        end
        spi_port_pkg::M_SHIFT:
          if (half_tick)
          begin
            next_sck_lvl = ~sck_lvl;
            next_edges   = edges + 4'h1;
            // leading edges sample in phase 0, trailing edges in phase 1
            if (sck_lvl == CLOCK_PHASE_BIT)
              next_in_bit = MISO_IN;
            else if (edges != 4'h0)                                        // keep msb for edge one
              next_shreg = {shreg[6:0], in_bit};
            if (edges == 4'(2 * spi_port_pkg::BITS_PER_BYTE - 1))
              next_state = spi_port_pkg::M_DONE;
          end
        spi_port_pkg::M_DONE:
        begin
          // phase 1 still owes the shift for the sample of the last edge
          next_shreg = mode_a ? shreg : {shreg[6:0], in_bit};
          next_rx    = mode_a ? shreg : {shreg[6:0], in_bit};
          next_rxv   = 1'b1;
          next_state = spi_port_pkg::M_IDLE;
        end
        default: next_state = spi_port_pkg::M_IDLE;
      endcase
    end
    else
    begin
      next_state   = spi_port_pkg::M_IDLE;
      next_sck_lvl = 1'b0;
      if (!slave_sel)
      begin
        // deselect ends the character; phase 0 needs this between bytes
        next_sl_cnt  = 4'h0;
        next_sl_load = 1'b1;
      end
      else
      begin
        if (sl_load)
        begin
          next_shreg   = fifo_valid ? fifo_data : spi_port_pkg::SHIFT_RST;
          next_sl_load = 1'b0;
        end
        if (s_sample)
          next_in_bit = MOSI_IN;
        // no shift before the first sample: msb must stand for the first capture
        if (s_shift && !sl_bits_z)
          next_shreg = {shreg[6:0], in_bit};
        if (s_sample)
        begin
          next_sl_cnt = sl_cnt + 4'h1;
          if (sl_cnt == 4'(spi_port_pkg::BITS_PER_BYTE - 1))
          begin
            next_rx      = {shreg[6:0], MOSI_IN};
            next_rxv     = 1'b1;
            next_sl_cnt  = 4'h0;
            next_sl_load = !mode_a;
          end
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state   <= spi_port_pkg::M_IDLE;
      shreg   <= spi_port_pkg::SHIFT_RST;
      edges   <= 4'h0;
      sck_lvl <= 1'b0;
      in_bit  <= 1'b0;
      rx      <= 8'h00;
      rxv     <= 1'b0;
      sck_d   <= 1'b0;
      ss_d    <= 1'b1;
      sl_cnt  <= 4'h0;
      sl_load <= 1'b1;
    end
    else if (CE)
    begin
      state   <= next_state;
      shreg   <= next_shreg;
      edges   <= next_edges;
      sck_lvl <= next_sck_lvl;
      in_bit  <= next_in_bit;
      rx      <= next_rx;
      rxv     <= next_rxv;
      sck_d   <= next_sck_d;
      ss_d    <= next_ss_d;
      sl_cnt  <= next_sl_cnt;
      sl_load <= next_sl_load;
    end
  end

  // pin drive: output only with direction bit and in its own role
  always_comb
  begin
    MOSI_OUT  = shreg[7];
    MISO_OUT  = shreg[7];
    SCK_OUT   = sck_lvl ^ CLOCK_POLARITY_BIT;
    MOSI_OE_N = !(master && DIR_MOSI);
    SCK_OE_N  = !(master && DIR_SCK);
    MISO_OE_N = !(slave_sel && DIR_MISO);
  end

  assign RX_DATA  = rx;
  assign RX_VALID = rxv;
  assign BUSY     = (state != spi_port_pkg::M_IDLE) || (slave_sel && !sl_bits_z);
endmodule : spi_master_slave_port

//--- verif/spi_port_props.sv
// pin-level assertions for the serial peripheral port
`timescale 1ns/100ps
module spi_port_props #(
  parameter int PRE = 2
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic MASTER_MODE,
  input wire logic CLOCK_POLARITY_BIT,
  input wire logic RATE_SELECT_LOW,
  input wire logic RATE_SELECT_HIGH,
  input wire logic DIR_MOSI,
  input wire logic RX_VALID,
  input wire logic BUSY,
  input wire logic MISO_OE_N,
  input wire logic MOSI_OE_N,
  input wire logic SCK_OUT,
  input wire logic SCK_OE_N,
  input wire logic SS_N_IN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic       tg;
  logic       sck_d;
  logic [4:0] nt;
  logic [4:0] next_nt;
  logic [7:0] gap;
  logic [7:0] next_gap;
  int         hp;
  // toggles since the last byte and cycles since the last toggle; gap saturates on long idles
  always_comb
  begin
    case ({RATE_SELECT_HIGH, RATE_SELECT_LOW})
      2'b00:   hp = PRE;
      2'b01:   hp = PRE * 2;
      2'b10:   hp = PRE * 8;
      default: hp = PRE * 16;
    endcase
    tg = MASTER_MODE && BUSY && (SCK_OUT != sck_d);
    next_nt = RX_VALID ? 5'h00 : nt + {4'h0, tg};
    next_gap = tg ? 8'h01 : gap + {7'h00, gap != 8'hFF};
  end
  always_ff @(posedge CORE_CLK)
  begin
    sck_d <= SCK_OUT;
    nt <= RST ? 5'h00 : next_nt;
    gap <= RST ? 8'hFF : next_gap;
  end
  miso_master_in_a: assert property (MASTER_MODE |-> MISO_OE_N)
    else $error("miso driven in master mode");
  mosi_slave_in_a: assert property (!MASTER_MODE |-> MOSI_OE_N)
    else $error("mosi driven in slave mode");
  sck_slave_in_a: assert property (!MASTER_MODE |-> SCK_OE_N)
    else $error("sck driven in slave mode");
  unsel_float_a: assert property ((!MASTER_MODE && SS_N_IN)[*3] |-> MISO_OE_N)
    else $error("unselected slave drives miso");
  dir_gate_a: assert property (!DIR_MOSI |-> MOSI_OE_N)
    else $error("mosi driven with direction bit clear");
  idle_sck_a: assert property (MASTER_MODE && !BUSY && !$past(BUSY) && $stable(CLOCK_POLARITY_BIT)
    |-> SCK_OUT == CLOCK_POLARITY_BIT)
    else $error("idle sck differs from polarity");
  byte_len_a: assert property (MASTER_MODE && RX_VALID |-> nt == 5'h10)
    else $error("byte not made of sixteen sck edges");
  rate_gap_a: assert property (tg && nt != 5'h00 |-> gap == hp[7:0])
    else $error("sck half period wrong for rate code");
  master_byte_c: cover property (MASTER_MODE && RX_VALID);
  slave_byte_c: cover property (!MASTER_MODE && RX_VALID);
  slow_rate_c: cover property (tg && hp == PRE * 16);
endmodule : spi_port_props
bind spi_master_slave_port spi_port_props #(.PRE(PRE)) props (.*);

//--- verif/spi_slave_model.sv
// behavioural far-side slave used while the port is master
`timescale 1ns/100ps
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic [7:0] tx,
  output      logic       miso,
  output      logic [7:0] rx,
  output      int         nbits
);
  int idx;
  initial miso = 1'b1;
  // a released line shows the inverse of its last level, never a stale copy
  always @(ss_n)
  begin
    idx = 0;
    nbits = 0;
    miso = ss_n ? ~miso : tx[7];
  end
  // phase 0 samples on the leading edge, phase 1 on the trailing edge
  always @(sck)
  begin
    if (!ss_n && ((sck != clock_polarity_bit) ^ clock_phase_bit))
    begin
      rx = {rx[6:0], mosi};
      nbits++;
    end
    else if (!ss_n)
    begin
      idx = idx + (clock_phase_bit ? 0 : 1);
      miso = tx[7 - (idx % 8)];
      idx = idx + (clock_phase_bit ? 1 : 0);
    end
  end
endmodule : spi_slave_model

//--- verif/tb.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/100ps
module tb;
  logic CORE_CLK, RST, CE, ENABLE, MASTER_MODE, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT;
  logic RATE_SELECT_LOW, RATE_SELECT_HIGH, DIR_MISO, DIR_MOSI, DIR_SCK, TX_VALID, TX_READY;
  logic RX_VALID, BUSY, MISO_OUT, MISO_OE_N, MOSI_IN, MOSI_OUT, MOSI_OE_N;
  logic SCK_IN, SCK_OUT, SCK_OE_N, SS_N_IN, m_miso, m_ss;
  logic [7:0] TX_DATA, RX_DATA, m_tx, m_rx, got;
  int         n_mismatch, tests_run, n_rx, m_bits;
  localparam int DV[4] = '{2, 4, 16, 32};
  spi_master_slave_port #(.PRE(2)) DUT (.*, .MISO_IN(m_miso));
  spi_slave_model PEER (.sck(SCK_OUT), .ss_n(m_ss), .mosi(MOSI_OUT), .clock_polarity_bit(CLOCK_POLARITY_BIT),
    .clock_phase_bit(CLOCK_PHASE_BIT), .tx(m_tx), .miso(m_miso), .rx(m_rx), .nbits(m_bits));
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // received bytes are latched here since the pulse lasts one cycle
  always @(posedge CORE_CLK)
  begin
    if (RX_VALID === 1'b1) got <= RX_DATA;
    if (RX_VALID === 1'b1) n_rx <= n_rx + 1;
  end
  task automatic check(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic mode(input logic ms, pol, ph, input logic [1:0] r);
    @(posedge CORE_CLK);
    {MASTER_MODE, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT, RATE_SELECT_HIGH, RATE_SELECT_LOW}
      <= {ms, pol, ph, r};
    repeat (4) @(posedge CORE_CLK);
  endtask : mode
  task automatic push(input logic [7:0] d);
    @(posedge CORE_CLK);
    TX_DATA <= d;
    TX_VALID <= 1'b1;
    @(posedge CORE_CLK) TX_VALID <= 1'b0;
  endtask : push
  task automatic wait_rx(input int n, cap, output int c);
    c = 0;
    while (n_rx < n && c < cap)
    begin
      @(negedge CORE_CLK);
      c++;
    end
  endtask : wait_rx
  task automatic t_dir();
    mode(1'b1, 1'b0, 1'b0, 2'b00);
    @(posedge CORE_CLK) {DIR_MOSI, DIR_SCK} <= 2'b00;
    @(negedge CORE_CLK);
    check(MOSI_OE_N, 1'b1);
    check(SCK_OE_N, 1'b1);
    check(MISO_OE_N, 1'b1);
    @(posedge CORE_CLK) {DIR_MOSI, DIR_SCK} <= 2'b11;
    @(negedge CORE_CLK);
    check(MOSI_OE_N, 1'b0);
    check(SCK_OE_N, 1'b0);
  endtask : t_dir
  task automatic t_master(input logic pol, ph, input logic [1:0] r, input logic [7:0] a, b);
    int c;
    int h;
    h = 16 * DV[r];
    mode(1'b1, pol, ph, r);
    m_tx = b;
    @(posedge CORE_CLK) m_ss <= 1'b0;
    push(a);
    wait_rx(n_rx + 1, 2000, c);
    check(got, b);
    check(m_rx, a);
    check(8'(m_bits), 8'h08);
    check(8'(c >= h - 2 && c <= h + 8), 8'h01);
    check(SCK_OUT, pol);
    @(posedge CORE_CLK) m_ss <= 1'b1;
  endtask : t_master
  task automatic t_slave(input logic ph, input logic [1:0] r, input logic [7:0] a, b);
    logic [7:0] s;
    int n;
    int c;
    n = n_rx;
    mode(1'b0, 1'b0, ph, r);
    push(b);
    @(negedge CORE_CLK);
    check(MISO_OE_N, 1'b1);
    @(posedge CORE_CLK) SS_N_IN <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (!ph) MOSI_IN <= a[7 - i];
      repeat (34) @(posedge CORE_CLK);
      SCK_IN <= 1'b1;
      if (ph) MOSI_IN <= a[7 - i];
      else s[7 - i] = MISO_OUT;
      repeat (34) @(posedge CORE_CLK);
      SCK_IN <= 1'b0;
      if (ph) s[7 - i] = MISO_OUT;
    end
    wait_rx(n + 1, 40, c);
    check(MOSI_OE_N, 1'b1);
    check(SCK_OE_N, 1'b1);
    check(MISO_OE_N, 1'b0);
    check(s, b);
    check(got, a);
    @(posedge CORE_CLK) SS_N_IN <= 1'b1;
    MOSI_IN <= ~MOSI_IN;
  endtask : t_slave
  task automatic t_fill();
    int k;
    int n;
    int c;
    k = 0;
    n = n_rx;
    mode(1'b1, 1'b0, 1'b1, 2'b00);
    m_tx = 8'hC3;
    @(posedge CORE_CLK) m_ss <= 1'b0;
    TX_DATA <= 8'h00;
    TX_VALID <= 1'b1;
    @(negedge CORE_CLK);
    while (TX_READY === 1'b1 && k < 40)
    begin
      k++;
      @(posedge CORE_CLK) TX_DATA <= 8'(k);
      @(negedge CORE_CLK);
    end
    @(posedge CORE_CLK) TX_VALID <= 1'b0;
    check(8'(k == 16 || k == 17), 8'h01);
    wait_rx(n + k, 3000, c);
    check(8'(n_rx - n), 8'(k));
    check(m_rx, 8'(k - 1));
    check(got, 8'hC3);
    check(TX_READY, 1'b1);
    @(posedge CORE_CLK) m_ss <= 1'b1;
  endtask : t_fill
  initial
  begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {RST, CE, ENABLE, DIR_MISO, DIR_MOSI, DIR_SCK, SS_N_IN, m_ss} = 8'hFF;
    {MASTER_MODE, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT, RATE_SELECT_LOW, RATE_SELECT_HIGH} = '0;
    {TX_VALID, TX_DATA, MOSI_IN, SCK_IN, m_tx} = '0;
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_dir();
    for (int m = 0; m < 16; m++) t_master(m[3], m[2], m[1:0], 8'hA5 ^ 8'(m), 8'h3C + 8'(m));
    t_slave(1'b0, 2'b00, 8'h96, 8'h5A);
    t_slave(1'b1, 2'b11, 8'h69, 8'hE1);
    t_fill();
    complete_run();
  end
endmodule : tb
